// ===== dv/cts_engine_model.sv
// Behavioural CAN engine facing the register slice: mode acks, buffer flags, events.
// Assumes the bench commands queueing and events on hclk, changing them after rising edges.
`timescale 1ns/1ns
module cts_engine_model #(
    parameter logic [7:0] RX_ERR = 8'h2c,
    parameter logic [7:0] TX_ERR = 8'h81
) (
    // Clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // Requests from the slice
    input  wire logic       init_request,
    input  wire logic       sleep_request,
    // Bench commands
    input  wire logic [2:0] queued,
    input  wire logic       bo_go,
    input  wire logic       rx_go,
    input  wire logic [2:0] rx_hit,
    // Status towards the slice
    output logic            init_acknowledge,
    output logic            sleep_acknowledge,
    output logic      [2:0] tx_empty_flag,
    output logic            busoff_enter,
    output logic            rx_shift,
    output logic      [2:0] rx_hit_index,
    output logic      [7:0] rx_error_value,
    output logic      [7:0] tx_error_value
);
    // ------------------------------------------------------------------
    // Mode handshake and events
    // ------------------------------------------------------------------
    // The hit index is only meaningful with the shift pulse, so it toggles
    // otherwise to expose any capture outside that cycle.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            init_acknowledge  <= 1'b0;
            sleep_acknowledge <= 1'b0;
            busoff_enter      <= 1'b0;
            rx_shift          <= 1'b0;
            rx_hit_index      <= 3'h0;
        end
        else
        begin
            init_acknowledge  <= init_request;
            sleep_acknowledge <= sleep_request;
            busoff_enter      <= bo_go;
            rx_shift          <= rx_go;
            rx_hit_index      <= rx_go ? rx_hit : ~rx_hit_index;
        end
    end

    assign tx_empty_flag  = ~queued;
    assign rx_error_value = RX_ERR;
    assign tx_error_value = TX_ERR;
endmodule

// ===== dv/cts_regs_asserts.sv
// Port-level checks for the CAN transmit-select and filter-control register slice.
// Assumes hready is the slice's own hreadyout, as with a single slave.
`timescale 1ns/1ns
module cts_regs_asserts (
    // Clock and reset
    input wire logic       hclk,
    input wire logic       hresetn,
    // Bus
    input wire logic       hsel,
    input wire logic [1:0] htrans,
    input wire logic       hready,
    input wire logic       hreadyout,
    input wire logic       hresp,
    // Engine side
    input wire logic       init_request,
    input wire logic       init_acknowledge,
    input wire logic       busoff_enter,
    input wire logic       busoff_recovery_mode,
    input wire logic       busoff_hold_flag,
    input wire logic       busoff_recover_req,
    input wire logic [1:0] acceptance_mode,
    input wire logic       filter_closed,
    input wire logic [2:0] tx_buffer_mapped
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_sel_init_clear: assert property (init_request && init_acknowledge |=>
        tx_buffer_mapped == 3'h0) else $error("select not cleared in init mode");
    a_map_one_hot: assert property ($onehot0(tx_buffer_mapped))
        else $error("more than one buffer mapped");
    a_closed_mode: assert property (filter_closed == (acceptance_mode == 2'h3))
        else $error("closed flag does not follow acceptance mode");
    a_hold_on_entry: assert property (busoff_recovery_mode && busoff_enter |=>
        busoff_hold_flag) else $error("hold flag not set on bus-off entry");
    a_recover_src: assert property (busoff_recover_req |-> $past(busoff_hold_flag))
        else $error("recovery request without hold flag");
    a_recover_clears: assert property (busoff_recover_req |-> !busoff_hold_flag)
        else $error("hold flag still set with recovery request");
    a_recover_pulse: assert property (busoff_recover_req |=> !busoff_recover_req)
        else $error("recovery request longer than one cycle");
    a_fall_requests: assert property ($fell(busoff_hold_flag) |-> busoff_recover_req)
        else $error("hold flag cleared without recovery request");
    a_one_wait: assert property (hsel && htrans[1] && hready |=>
        !hreadyout ##1 hreadyout) else $error("transfer not one wait state");
    a_resp_okay: assert property (!hresp)
        else $error("error response on bus");

    c_recover: cover property (busoff_recover_req);
    c_closed: cover property (filter_closed);
    c_map_one: cover property (tx_buffer_mapped == 3'h2);
endmodule

bind cts_regs cts_regs_asserts u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .init_request(init_request),
    .init_acknowledge(init_acknowledge), .busoff_enter(busoff_enter),
    .busoff_recovery_mode(busoff_recovery_mode), .busoff_hold_flag(busoff_hold_flag),
    .busoff_recover_req(busoff_recover_req), .acceptance_mode(acceptance_mode),
    .filter_closed(filter_closed), .tx_buffer_mapped(tx_buffer_mapped)
);

// ===== dv/tb_cts_regs.sv
// Self-checking bench for the CAN transmit-select and filter-control register slice.
// Assumes the behavioural engine model on the far side and the bound port checker.
`timescale 1ns/1ns
module tb_cts_regs;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        init_request;
    logic        sleep_request;
    logic        init_acknowledge;
    logic        sleep_acknowledge;
    logic [2:0]  tx_empty_flag;
    logic        busoff_enter;
    logic        rx_shift;
    logic [2:0]  rx_hit_index;
    logic [7:0]  rx_error_value;
    logic [7:0]  tx_error_value;
    logic        busoff_hold_flag;
    logic        filter_closed;
    logic [2:0]  tx_buffer_mapped;
    logic        irq;
    logic [2:0]  queued;
    logic        bo_go;
    logic        rx_go;
    logic [2:0]  rx_hit;
    logic        rdy_pre;
    logic [31:0] rd_pre;
    logic [31:0] v;
    int          num_errors;
    int          checks;
    int          i;

    cts_regs dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
        .init_acknowledge(init_acknowledge), .sleep_acknowledge(sleep_acknowledge),
        .tx_empty_flag(tx_empty_flag), .busoff_enter(busoff_enter), .rx_shift(rx_shift),
        .rx_hit_index(rx_hit_index), .rx_error_value(rx_error_value),
        .tx_error_value(tx_error_value), .init_request(init_request),
        .sleep_request(sleep_request), .busoff_recovery_mode(),
        .busoff_hold_flag(busoff_hold_flag), .busoff_recover_req(),
        .acceptance_mode(), .filter_closed(filter_closed),
        .tx_buffer_mapped(tx_buffer_mapped), .irq(irq)
    );

    cts_engine_model u_eng (
        .hclk(hclk), .hresetn(hresetn), .init_request(init_request),
        .sleep_request(sleep_request), .queued(queued), .bo_go(bo_go), .rx_go(rx_go),
        .rx_hit(rx_hit), .init_acknowledge(init_acknowledge),
        .sleep_acknowledge(sleep_acknowledge), .tx_empty_flag(tx_empty_flag),
        .busoff_enter(busoff_enter), .rx_shift(rx_shift), .rx_hit_index(rx_hit_index),
        .rx_error_value(rx_error_value), .tx_error_value(tx_error_value)
    );

    // ------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------
    // Values seen just before each rising edge, so sampling never races the slice.
    always @(negedge hclk)
    begin
        rdy_pre = hreadyout;
        rd_pre  = hrdata;
    end

    task automatic summarize;
        if (num_errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wait_rdy;
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (rdy_pre !== 1'b1 && n < 20);
        if (rdy_pre !== 1'b1)
        begin
            num_errors++;
            summarize();
        end
    endtask

    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        v = rd_pre;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0);
        chk(v, e);
    endtask

    // One engine event, then time for it to land in the registers.
    task automatic ev(input logic bo, input logic [2:0] h);
        @(posedge hclk);
        bo_go  <= bo;
        rx_go  <= !bo;
        rx_hit <= h;
        @(posedge hclk);
        bo_go <= 1'b0;
        rx_go <= 1'b0;
        repeat (2) @(posedge hclk);
        @(negedge hclk);
    endtask

    initial
    begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        {hresetn, hsel, hwrite, bo_go, rx_go} = 5'h0;
        {haddr, hwdata, htrans, queued, rx_hit} = '0;
        num_errors = 0;
        checks = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(8'h14, 32'h1); // init after reset
        rdc(8'h04, 32'h0); // reset mode
        wr(8'h00, 32'h3);
        rdc(8'h00, 32'h0); // held clear
        rdc(8'h0c, 32'h2c); // count in init
        rdc(8'h10, 32'h81); // count in init
        for (i = 0; i < 4; i++)
        begin
            wr(8'h04, {26'h0, i[1:0], 4'h7});
            rdc(8'h04, {26'h0, i[1:0], 4'h0}); // hit read-only
            chk({31'h0, filter_closed}, {31'h0, i == 3}); // closed mode
        end
        wr(8'h04, 32'h0);
        for (i = 0; i < 8; i++)
        begin
            ev(1'b0, i[2:0]);
            rdc(8'h04, i); // hit follows
        end
        wr(8'h04, 32'h30);
        ev(1'b0, 3'h2);
        rdc(8'h04, 32'h37); // old hit kept
        wr(8'h14, 32'h4);
        wr(8'h04, 32'h10);
        rdc(8'h04, 32'h37); // no write outside init
        rdc(8'h0c, 32'h0); // hidden
        wr(8'h14, 32'h6);
        rdc(8'h10, 32'h81); // count in sleep
        wr(8'h14, 32'h4);
        queued <= 3'h1;
        xfer(8'h18, 1'b0, 32'h0);
        wr(8'h00, {29'h0, v[6:4]}); // flags copied to select
        rdc(8'h00, 32'h2);
        chk({29'h0, tx_buffer_mapped}, 32'h2);
        wr(8'h40, 32'hcafe_0001);
        rdc(8'h40, 32'hcafe_0001); // free buffer
        wr(8'h00, 32'h7);
        rdc(8'h00, 32'h1);
        rdc(8'h40, 32'h0); // queued refused
        rdc(8'h1c, 32'h6); // refusal flagged
        wr(8'h00, 32'h0);
        rdc(8'h00, 32'h0);
        rdc(8'h44, 32'h0);
        wr(8'h20, 32'h4);
        ev(1'b0, 3'h0);
        chk({31'h0, irq}, 32'h1); // unmasked
        wr(8'h20, 32'h0);
        ev(1'b0, 3'h0);
        chk({31'h0, irq}, 32'h0); // masked
        wr(8'h20, 32'h4);
        wr(8'h1c, 32'h7);
        ev(1'b0, 3'h0);
        chk({31'h0, irq}, 32'h0); // cleared
        ev(1'b1, 3'h0);
        chk({31'h0, busoff_hold_flag}, 32'h1);
        rdc(8'h08, 32'h1);
        wr(8'h08, 32'h0);
        rdc(8'h08, 32'h1); // zero ignored
        wr(8'h08, 32'h1);
        rdc(8'h08, 32'h0); // one clears
        rdc(8'h1c, 32'h1); // event recorded
        rdc(8'h30, 32'h0); // unmapped
        summarize();
    end
endmodule

// ===== verilog/cts_pkg.sv
// Constants and carrier types for the CAN transmit-select and filter-control register slice.
// Assumes one AHB-Lite master and a CAN engine on the same clock as the registers.
package cts_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_TX_BUFFER_SELECT   = 8'h00;
    localparam logic [7:0] OFS_ACCEPTANCE_CONTROL = 8'h04;
    localparam logic [7:0] OFS_MISC_BUSOFF_HOLD   = 8'h08;
    localparam logic [7:0] OFS_RX_ERROR_COUNT     = 8'h0c;
    localparam logic [7:0] OFS_TX_ERROR_COUNT     = 8'h10;
    localparam logic [7:0] OFS_MODE_CONTROL       = 8'h14;
    localparam logic [7:0] OFS_MODE_STATUS        = 8'h18;
    localparam logic [7:0] OFS_IRQ_STATUS         = 8'h1c;
    localparam logic [7:0] OFS_IRQ_MASK           = 8'h20;
    localparam logic [3:0] OFS_TX_WINDOW_PAGE     = 4'h4;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int NUM_TX_BUFFERS    = 3;
    localparam int WINDOW_WORDS      = 4;
    localparam int ACC_MODE_LSB      = 4;
    localparam int ACC_HIT_LSB       = 0;
    localparam int BUSOFF_HOLD_BIT   = 0;
    localparam int CTRL_INIT_BIT     = 0;
    localparam int CTRL_SLEEP_BIT    = 1;
    localparam int CTRL_RECOVERY_BIT = 2;
    localparam int STAT_INIT_ACK_BIT = 0;
    localparam int STAT_SLEEP_ACK_BIT = 1;
    localparam int STAT_EMPTY_LSB    = 4;
    localparam int IRQ_BUSOFF_BIT    = 0;
    localparam int IRQ_RX_HIT_BIT    = 1;
    localparam int IRQ_BLOCKED_BIT   = 2;
    localparam int NUM_IRQ           = 3;

    // ------------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------------
    localparam logic [2:0] RST_TX_BUFFER_SELECT = 3'h0;
    localparam logic [1:0] RST_ACCEPTANCE_MODE  = 2'h0;
    localparam logic [2:0] RST_HIT_INDEX        = 3'h0;
    localparam logic [2:0] RST_MODE_CONTROL     = 3'h1;
    localparam logic [2:0] RST_IRQ              = 3'h0;

    typedef enum logic [1:0] {
        ACC_TWO_32    = 2'h0,
        ACC_FOUR_16   = 2'h1,
        ACC_EIGHT_8   = 2'h2,
        ACC_CLOSED    = 2'h3
    } cts_acc_mode_t;

    typedef enum logic {
        BUS_IDLE,
        BUS_COMMIT
    } cts_bus_state_t;

    // Captured address phase of one bus transfer.
    typedef struct packed {
        logic       write;
        logic [7:0] addr;
    } cts_dphase_t;

    // Receive-side report of a message reaching the foreground buffer.
    typedef struct packed {
        logic       shift;
        logic [2:0] hit_index;
    } cts_rx_event_t;

endpackage

// ===== verilog/cts_regs.sv
// Register slice of a CAN controller: transmit buffer select and window, acceptance
// control with hit index, bus-off hold, error counter views and an interrupt.
// Assumes the CAN engine inputs are on hclk and need no synchroniser.
// Functional notes
// - In init mode buffer select is forced to reset; writes only outside init.
// - Buffer select reads back only its lowest set bit.
// - Lowest set select bit maps that transmit buffer into the window.
// - Window access is blocked while the mapped buffer is queued.
// - With no buffer selected, every window access is refused.
// - Acceptance control readable always, writable in init only, hit read-only.
// - Acceptance mode chooses 2x32, 4x16, 8x8 filters or closed.
// - In closed mode no message reloads the foreground buffer.
// - Hit index holds the number of the matching filter.
// - Hit index updates whenever a message shifts into the foreground.
// - With recovery mode on, entering bus-off sets and holds the hold flag.
// - Writing one clears the hold flag and requests recovery; zero ignored.
// - Receive error count is read-only, valid in sleep or init mode.
// - Transmit error count is read-only, valid in sleep or init mode.
// - Empty flag one means free buffer; zero means queued.
//
// Added by the designer: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ns
module cts_regs (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // CAN engine status
    input  wire logic        init_acknowledge,
    input  wire logic        sleep_acknowledge,
    input  wire logic [2:0]  tx_empty_flag,
    input  wire logic        busoff_enter,
    input  wire logic        rx_shift,
    input  wire logic [2:0]  rx_hit_index,
    input  wire logic [7:0]  rx_error_value,
    input  wire logic [7:0]  tx_error_value,
    // CAN engine control
    output logic             init_request,
    output logic             sleep_request,
    output logic             busoff_recovery_mode,
    output logic             busoff_hold_flag,
    output logic             busoff_recover_req,
    output logic      [1:0]  acceptance_mode,
    output logic             filter_closed,
    output logic      [2:0]  tx_buffer_mapped,
    // Interrupt
    output logic             irq
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Keeps only the lowest set bit of a select field.
    function automatic logic [2:0] lowest_set(input logic [2:0] v);
        return v & (~v + 3'h1);
    endfunction

    // Turns a one-hot buffer choice into its index; no choice gives buffer 0.
    function automatic logic [1:0] onehot_index(input logic [2:0] v);
        return {v[2], v[1]};
    endfunction

    // ------------------------------------------------------------------
    // Bus capture
    // ------------------------------------------------------------------
    cts_pkg::cts_bus_state_t bus_state;
    cts_pkg::cts_dphase_t    dphase;
    cts_pkg::cts_rx_event_t  rx_event;
    logic                    addr_take;
    logic                    wr;
    logic                    rd;

    logic [2:0]  tx_buffer_select;
    logic [2:0]  hit_index;
    logic [2:0]  irq_status;
    logic [2:0]  irq_mask;
    logic [2:0]  irq_event;
    logic [2:0]  next_tx_buffer_select;
    logic [31:0] tx_window [0:cts_pkg::NUM_TX_BUFFERS*cts_pkg::WINDOW_WORDS-1];
    logic        init_mode;
    logic        sleep_mode;
    logic        win_access;
    logic        win_allowed;
    logic [2:0]  mapped_now;
    logic [3:0]  win_index;
    logic [31:0] rdata_mux;

    assign addr_take = hsel && htrans[1] && hready;
    assign wr        = (bus_state == cts_pkg::BUS_COMMIT) && dphase.write;
    assign rd        = (bus_state == cts_pkg::BUS_COMMIT) && !dphase.write;
    assign init_mode  = init_request && init_acknowledge;
    assign sleep_mode = sleep_request && sleep_acknowledge;
    assign rx_event   = '{shift: rx_shift, hit_index: rx_hit_index};

    // Every transfer takes one wait state, so a write is committed before any later read
    // samples the registers. Refused accesses still answer OKAY and set the blocked interrupt status bit.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bus_state <= cts_pkg::BUS_IDLE;
            dphase    <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
        end
        else
        begin
            hresp <= 1'b0;
            if (rd)
            begin
                hrdata <= rdata_mux;
            end
            unique case (bus_state)
                cts_pkg::BUS_IDLE:
                begin
                    if (addr_take)
                    begin
                        bus_state <= cts_pkg::BUS_COMMIT;
                        dphase    <= '{write: hwrite, addr: haddr[7:0]};
                        hreadyout <= 1'b0;
                    end
                end
                cts_pkg::BUS_COMMIT:
                begin
                    bus_state <= cts_pkg::BUS_IDLE;
                    hreadyout <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Transmit buffer select and window
    // ------------------------------------------------------------------
    always_comb
    begin
        next_tx_buffer_select = tx_buffer_select;
        if (init_mode)
        begin
            next_tx_buffer_select = cts_pkg::RST_TX_BUFFER_SELECT;
        end
        else if (wr && dphase.addr == cts_pkg::OFS_TX_BUFFER_SELECT &&
                 !init_request && !init_acknowledge)
        begin
            next_tx_buffer_select = hwdata[2:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tx_buffer_select <= cts_pkg::RST_TX_BUFFER_SELECT;
            tx_buffer_mapped <= cts_pkg::RST_TX_BUFFER_SELECT;
        end
        else
        begin
            tx_buffer_select <= next_tx_buffer_select;
            tx_buffer_mapped <= lowest_set(next_tx_buffer_select);
        end
    end

    assign mapped_now = lowest_set(tx_buffer_select);
    assign win_access = (bus_state == cts_pkg::BUS_COMMIT) &&
                        (dphase.addr[7:4] == cts_pkg::OFS_TX_WINDOW_PAGE);
    assign win_allowed = |(mapped_now & tx_empty_flag);
    assign win_index   = {onehot_index(mapped_now), dphase.addr[3:2]};

    always_ff @(posedge hclk)
    begin
        if (win_access && win_allowed && dphase.write)
        begin
            tx_window[win_index] <= hwdata;
        end
    end

    // ------------------------------------------------------------------
    // Acceptance control and hit index
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            acceptance_mode <= cts_pkg::RST_ACCEPTANCE_MODE;
            filter_closed   <= 1'b0;
        end
        else if (wr && dphase.addr == cts_pkg::OFS_ACCEPTANCE_CONTROL && init_mode)
        begin
            acceptance_mode <= hwdata[cts_pkg::ACC_MODE_LSB +: 2];
            filter_closed   <= hwdata[cts_pkg::ACC_MODE_LSB +: 2] == cts_pkg::ACC_CLOSED;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hit_index <= cts_pkg::RST_HIT_INDEX;
        end
        else if (rx_event.shift && !filter_closed)
        begin
            hit_index <= rx_event.hit_index;
        end
    end

    // ------------------------------------------------------------------
    // Bus-off hold and mode control
    // ------------------------------------------------------------------
    logic hold_clear;
    assign hold_clear = wr && dphase.addr == cts_pkg::OFS_MISC_BUSOFF_HOLD &&
                        hwdata[cts_pkg::BUSOFF_HOLD_BIT];
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            busoff_hold_flag   <= 1'b0;
            busoff_recover_req <= 1'b0;
        end
        else
        begin
            busoff_recover_req <= hold_clear && busoff_hold_flag &&
                                  !(busoff_enter && busoff_recovery_mode);
            if (busoff_enter && busoff_recovery_mode)
            begin
                busoff_hold_flag <= 1'b1;
            end
            else if (hold_clear)
            begin
                busoff_hold_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            {busoff_recovery_mode, sleep_request, init_request} <= cts_pkg::RST_MODE_CONTROL;
        end
        else if (wr && dphase.addr == cts_pkg::OFS_MODE_CONTROL)
        begin
            init_request         <= hwdata[cts_pkg::CTRL_INIT_BIT];
            sleep_request        <= hwdata[cts_pkg::CTRL_SLEEP_BIT];
            busoff_recovery_mode <= hwdata[cts_pkg::CTRL_RECOVERY_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    assign irq_event[cts_pkg::IRQ_BUSOFF_BIT]  = busoff_enter;
    assign irq_event[cts_pkg::IRQ_RX_HIT_BIT]  = rx_event.shift && !filter_closed;
    assign irq_event[cts_pkg::IRQ_BLOCKED_BIT] = win_access && !win_allowed;

    // A new event in the clearing cycle wins, so no event is lost.
    for (genvar gi = 0; gi < cts_pkg::NUM_IRQ; gi++)
    begin : g_irq
        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
            begin
                irq_status[gi] <= 1'b0;
            end
            else if (irq_event[gi])
            begin
                irq_status[gi] <= 1'b1;
            end
            else if (wr && dphase.addr == cts_pkg::OFS_IRQ_STATUS && hwdata[gi])
            begin
                irq_status[gi] <= 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_mask <= cts_pkg::RST_IRQ;
            irq      <= 1'b0;
        end
        else
        begin
            if (wr && dphase.addr == cts_pkg::OFS_IRQ_MASK)
            begin
                irq_mask <= hwdata[2:0];
            end
            irq <= |(irq_status & irq_mask);
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_comb
    begin
        rdata_mux = 32'h0000_0000;
        if (dphase.addr[7:4] == cts_pkg::OFS_TX_WINDOW_PAGE)
        begin
            rdata_mux = win_allowed ? tx_window[win_index] : 32'h0000_0000;
        end
        else
        begin
            unique case (dphase.addr)
                cts_pkg::OFS_TX_BUFFER_SELECT:
                    rdata_mux[2:0] = mapped_now;
                cts_pkg::OFS_ACCEPTANCE_CONTROL:
                begin
                    rdata_mux[cts_pkg::ACC_MODE_LSB +: 2] = acceptance_mode;
                    rdata_mux[cts_pkg::ACC_HIT_LSB +: 3]  = hit_index;
                end
                cts_pkg::OFS_MISC_BUSOFF_HOLD:
                    rdata_mux[cts_pkg::BUSOFF_HOLD_BIT] = busoff_hold_flag;
                // receive count in sleep or init
                cts_pkg::OFS_RX_ERROR_COUNT:
                    rdata_mux[7:0] = (init_mode || sleep_mode) ? rx_error_value : 8'h00;
                // transmit count in sleep or init
                cts_pkg::OFS_TX_ERROR_COUNT:
                    rdata_mux[7:0] = (init_mode || sleep_mode) ? tx_error_value : 8'h00;
                cts_pkg::OFS_MODE_CONTROL:
                begin
                    rdata_mux[cts_pkg::CTRL_INIT_BIT]     = init_request;
                    rdata_mux[cts_pkg::CTRL_SLEEP_BIT]    = sleep_request;
                    rdata_mux[cts_pkg::CTRL_RECOVERY_BIT] = busoff_recovery_mode;
                end
                cts_pkg::OFS_MODE_STATUS:
                begin
                    rdata_mux[cts_pkg::STAT_INIT_ACK_BIT]  = init_acknowledge;
                    rdata_mux[cts_pkg::STAT_SLEEP_ACK_BIT] = sleep_acknowledge;
                    rdata_mux[cts_pkg::STAT_EMPTY_LSB +: 3] = tx_empty_flag;
                end
                cts_pkg::OFS_IRQ_STATUS:
                    rdata_mux[2:0] = irq_status;
                cts_pkg::OFS_IRQ_MASK:
                    rdata_mux[2:0] = irq_mask;
                default:
                    rdata_mux = 32'h0000_0000;
            endcase
        end
    end

endmodule
